// *** hw/fmw_unit.sv ***
// Functional notes
// - enabled square_root_function writes root, else idle
// - negative square_root_function source faults, no write
// - too-large result sets overflow, infinity out
// - exp computes e power of source
// - too-small exp result sets underflow, zero
// - log computes natural log; negative faults
// - non-float source faults and skips
// - float zero flag: exponent and mantissa zero
// - float pair: high half in next word
// - bad indirect pointer sets fault
// - complement inverts every target bit
// - plain form every scan, edge once
// - bitwise AND of two inputs
// - bitwise inclusive OR of two inputs
// - bitwise exclusive OR of two inputs
// - bitwise exclusive NOR of two inputs
// - word zero flag set when result zero
// - float results never aimed at reserved words
// - word results never aimed at reserved words
// - third float operand always constant zero
//
// Purpose: execution unit for float math and word logic
// Assumes: sequencer waits for ack before the next request
// Notes: float results are truncated, not IEEE rounded
`timescale 1ns/10ps
module fmw_unit #(
  parameter int          SLOTS     = fmw_pkg::SLOTS_DEF,
  parameter logic [15:0] PTR_LIMIT = fmw_pkg::PTR_LIMIT_DEF
) (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // sequencer link
  fmw_if.dev        bus,
  // status
  output logic      busy_o
);
  if (SLOTS < 1 || SLOTS > (1 << fmw_pkg::SLOT_W)) begin : g_bad_slots
    $error("fmw_unit: SLOTS out of range");
  end
  typedef enum logic [9:0] {
    S_IDLE  = 10'h001,
    S_SQUARE_ROOT_FUNCTION  = 10'h002,
    S_LOG   = 10'h004,
    S_LNMUL = 10'h008,
    S_NORM  = 10'h010,
    S_EXPY  = 10'h020,
    S_EXPR  = 10'h040,
    S_EXPT  = 10'h080,
    S_EXPSQ = 10'h100,
    S_FIN   = 10'h200
  } fmw_state_e;
  function automatic logic is_bcd(input logic [15:0] w);
    is_bcd = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (w[4*i+3 -: 4] > 4'h9) is_bcd = 1'b0;
    end
  endfunction : is_bcd
  // returns {overflow, underflow, float word}
  function automatic logic [33:0] fmw_pack(input logic s, input logic signed [9:0] be, input logic [22:0] f);
    if (be >= fmw_pkg::BEXP_TOP) fmw_pack = {2'b10, s ? fmw_pkg::NEG_INF : fmw_pkg::POS_INF};
    else if (be <= fmw_pkg::BEXP_NONE) fmw_pack = {2'b01, fmw_pkg::FLT_ZERO};
    else fmw_pack = {2'b00, s, be[7:0], f};
  endfunction : fmw_pack
  fmw_state_e          state;
  logic [5:0]          cnt;
  logic [63:0]         acc;
  logic [47:0]         rad;
  logic [26:0]         rem;
  logic [23:0]         root;
  logic [22:0]         lfrac;
  logic signed [9:0]   nexp;
  logic                xsgn;
  logic                skip;
  logic                fault;
  logic                wrq;
  logic                is_flt;
  logic                ovf;
  logic                unf;
  logic [31:0]         res_w;
  logic [SLOTS-1:0]    edge_mem;
  ////////////////////////////////////////////////////////////////////////
  // request decode
  wire [31:0]        src      = {bus.src_hi, bus.src_lo};
  wire               src_sgn  = src[fmw_pkg::FLT_SIGN];
  wire [7:0]         src_exp  = src[fmw_pkg::EXP_MSB:fmw_pkg::EXP_LSB];
  wire [23:0]        src_man  = {1'b1, src[fmw_pkg::FRAC_MSB:0]};
  wire               src_bad  = src_exp == fmw_pkg::EXP_SPECIAL;
  wire               src_zero = src_exp == fmw_pkg::EXP_ZERO;
  wire signed [9:0]  src_e    = $signed({2'b00, src_exp}) - fmw_pkg::BEXP_BIAS;
  wire signed [9:0]  sq_e     = (src_e - $signed({9'h000, src_e[0]})) >>> 1;
  wire               ptr_bad  = bus.ind && (!is_bcd(bus.ptr) || bus.ptr > PTR_LIMIT);
  wire               op_flt   = bus.op == fmw_pkg::OP_SQUARE_ROOT_FUNCTION || bus.op == fmw_pkg::OP_EXP || bus.op == fmw_pkg::OP_LOG;
  wire               op_bad   = bus.op > fmw_pkg::OP_XNOR;
  wire               slot_ok  = int'(bus.slot) < SLOTS;
  wire               prev_on  = slot_ok && edge_mem[bus.slot];
  wire               fire     = bus.cond && !(bus.edge_form && prev_on);
  wire               exp_big  = !src_zero && src_e >= fmw_pkg::EXP_IN_MAX;

  wire [15:0] logic_res =
    (bus.op == fmw_pkg::OP_INV) ? ~bus.in1 :
    (bus.op == fmw_pkg::OP_AND) ? (bus.in1 & bus.in2) :
    (bus.op == fmw_pkg::OP_OR)  ? (bus.in1 | bus.in2) :
    (bus.op == fmw_pkg::OP_XOR) ? (bus.in1 ^ bus.in2) :
    ~(bus.in1 ^ bus.in2);

  // source magnitude as Q.30 fixed point for the exponential
  wire [63:0] x_base = {33'h0, src_man, 7'h00};
  wire [63:0] x_fix  = src_zero ? 64'h0 :
                       src_e[9] ? (x_base >> 10'(-src_e)) : (x_base << src_e[2:0]);

  ////////////////////////////////////////////////////////////////////////
  // shared multiplier and datapath terms
  wire signed [32:0] lval  = $signed({nexp, lfrac});
  wire [39:0]        lmag  = 40'(lval[32] ? -lval : lval);
  wire [39:0]        op_a  = (state == S_LNMUL) ? lmag : acc[39:0];
  wire [39:0]        op_b  = (state == S_EXPY) ? {8'h00, fmw_pkg::LOG2E_Q31} :
                             (state == S_EXPR || state == S_LNMUL) ? {8'h00, fmw_pkg::LN2_Q32} : acc[39:0];
  wire [79:0]        prod  = op_a * op_b;
  wire [47:0]        y_mag = prod[78:31];
  wire [47:0]        y_sgn = xsgn ? -y_mag : y_mag;
  wire [26:0]        sq_r  = {rem[24:0], rad[47:46]};
  wire [26:0]        sq_t  = {1'b0, root, 2'b01};
  wire               sq_ge = sq_r >= sq_t;
  wire signed [9:0]  bexp  = nexp + fmw_pkg::BEXP_BIAS;

  ////////////////////////////////////////////////////////////////////////
  // edge-form history per instruction slot
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      edge_mem <= '0;
    end else if (state == S_IDLE && bus.req && slot_ok) begin
      edge_mem[bus.slot] <= bus.cond;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= S_IDLE;
      {cnt, acc, rad, rem, root, lfrac, nexp} <= '0;
      {xsgn, skip, fault, wrq, is_flt, ovf, unf, busy_o} <= '0;
      res_w <= fmw_pkg::FLT_ZERO;
      {bus.ack, bus.wr, bus.fault, bus.zero, bus.ovf, bus.unf} <= '0;
      {bus.res_lo, bus.res_hi} <= '0;
    end else begin
      bus.ack <= 1'b0;
      bus.wr  <= 1'b0;
      case (state)
        S_IDLE: if (bus.req) begin
          busy_o <= 1'b1;
          state  <= S_FIN;
          skip   <= !fire;
          is_flt <= op_flt;
          xsgn   <= src_sgn;
          {fault, wrq, ovf, unf} <= 4'h0;
          cnt    <= 6'h00;
          if (!fire) begin
          end else if (ptr_bad || op_bad || (op_flt && src_bad)) begin
            fault <= 1'b1;
          end else if (!op_flt) begin
            res_w <= {16'h0000, logic_res};
            wrq   <= 1'b1;
          end else if (src_sgn && !src_zero && bus.op != fmw_pkg::OP_EXP) begin
            fault <= 1'b1;
          end else if (bus.op == fmw_pkg::OP_SQUARE_ROOT_FUNCTION) begin
            wrq <= 1'b1;
            if (src_zero) begin
              res_w <= fmw_pkg::FLT_ZERO;
            end else begin
              rad   <= src_e[0] ? {src_man, 24'h000000} : {1'b0, src_man, 23'h000000};
              rem   <= '0;
              root  <= '0;
              nexp  <= sq_e;
              state <= S_SQUARE_ROOT_FUNCTION;
            end
          end else if (bus.op == fmw_pkg::OP_LOG) begin
            wrq <= 1'b1;
            if (src_zero) begin
              res_w <= fmw_pkg::NEG_INF;
              ovf   <= 1'b1;
            end else begin
              acc   <= {40'h0, src_man};
              lfrac <= '0;
              nexp  <= src_e;
              state <= S_LOG;
            end
          end else begin
            wrq <= 1'b1;
            if (exp_big) begin
              res_w <= src_sgn ? fmw_pkg::FLT_ZERO : fmw_pkg::POS_INF;
              unf   <= src_sgn;
              ovf   <= !src_sgn;
            end else begin
              acc   <= x_fix;
              state <= S_EXPY;
            end
          end
        end
        S_SQUARE_ROOT_FUNCTION: if (cnt == fmw_pkg::SQUARE_ROOT_FUNCTION_ITERS) begin
          {ovf, unf, res_w} <= fmw_pack(1'b0, bexp, root[22:0]);
          state <= S_FIN;
        end else begin
          rem  <= sq_ge ? sq_r - sq_t : sq_r;
          root <= {root[22:0], sq_ge};
          rad  <= {rad[45:0], 2'b00};
          cnt  <= cnt + 6'h01;
        end
        S_LOG: if (cnt == fmw_pkg::LOG_ITERS) begin
          state <= S_LNMUL;
        end else begin
          lfrac <= {lfrac[21:0], prod[47]};
          acc   <= {40'h0, prod[47] ? prod[47:24] : prod[46:23]};
          cnt   <= cnt + 6'h01;
        end
        S_LNMUL: begin
          acc   <= prod[63:0];
          xsgn  <= lval[32];
          nexp  <= fmw_pkg::LN_EXP_INIT;
          res_w <= fmw_pkg::FLT_ZERO;
          state <= (prod[63:0] == 64'h0) ? S_FIN : S_NORM;
        end
        S_NORM: if (acc[63]) begin
          {ovf, unf, res_w} <= fmw_pack(xsgn, bexp, acc[62:40]);
          state <= S_FIN;
        end else begin
          acc  <= {acc[62:0], 1'b0};
          nexp <= nexp - 10'sh001;
        end
        S_EXPY: begin
          nexp  <= $signed(y_sgn[39:30]);
          acc   <= {34'h0, y_sgn[29:0]};
          state <= S_EXPR;
        end
        S_EXPR: begin
          acc   <= 64'(prod[61:40]);
          state <= S_EXPT;
        end
        S_EXPT: begin
          acc   <= fmw_pkg::ONE_Q30 + acc + 64'(prod[79:31]);
          state <= S_EXPSQ;
        end
        S_EXPSQ: if (cnt == fmw_pkg::EXP_SQUARINGS) begin
          {ovf, unf, res_w} <= fmw_pack(1'b0, bexp, acc[29:7]);
          state <= S_FIN;
        end else begin
          acc <= 64'(prod[79:30]);
          cnt <= cnt + 6'h01;
        end
        S_FIN: begin
          bus.ack <= 1'b1;
          busy_o  <= 1'b0;
          state   <= S_IDLE;
          if (!skip) begin
            bus.wr     <= wrq && !fault;
            bus.res_lo <= res_w[15:0];
            bus.res_hi <= res_w[31:16];
            bus.fault  <= fault;
            bus.ovf    <= ovf;
            bus.unf    <= unf;
            bus.zero   <= !fault && (is_flt ? res_w[30:0] == 31'h0 : res_w[15:0] == 16'h0);
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule : fmw_unit

// *** hw/fmw_pkg.sv ***
// Purpose: shared constants for the float math and word logic unit
// Assumes: operand words are 16 bits, floats are single format
// Notes: fixed-point work values of the exponential carry 30 fraction bits
package fmw_pkg;
  localparam int              WORD_W        = 16;
  localparam int              SLOT_W        = 4;
  localparam int              SLOTS_DEF     = 16;
  // float field positions
  localparam int              FLT_SIGN      = 31;
  localparam int              EXP_MSB       = 30;
  localparam int              EXP_LSB       = 23;
  localparam int              FRAC_MSB      = 22;
  localparam logic [7:0]      EXP_SPECIAL   = 8'hFF;
  localparam logic [7:0]      EXP_ZERO      = 8'h00;
  localparam logic signed [9:0] BEXP_BIAS   = 10'sh07F;
  localparam logic signed [9:0] BEXP_TOP    = 10'sh0FF;
  localparam logic signed [9:0] BEXP_NONE   = 10'sh000;
  localparam logic signed [9:0] LN_EXP_INIT = 10'sh008;
  localparam logic signed [9:0] EXP_IN_MAX  = 10'sh007;
  localparam logic [31:0]     POS_INF       = 32'h7F80_0000;
  localparam logic [31:0]     NEG_INF       = 32'hFF80_0000;
  localparam logic [31:0]     FLT_ZERO      = 32'h0000_0000;
  // ln 2 as Q0.32, log2 of the constant e = 2.718282 as Q1.31
  localparam logic [31:0]     LN2_Q32       = 32'hB172_17F8;
  localparam logic [31:0]     LOG2E_Q31     = 32'hB8AA_3B29;
  localparam logic [63:0]     ONE_Q30       = 64'h0000_0000_4000_0000;
  // iteration counts
  localparam logic [5:0]      SQUARE_ROOT_FUNCTION_ITERS    = 6'h18;
  localparam logic [5:0]      LOG_ITERS     = 6'h17;
  localparam logic [5:0]      EXP_SQUARINGS = 6'h08;
  // operation codes
  localparam logic [3:0]      OP_SQUARE_ROOT_FUNCTION       = 4'h0;
  localparam logic [3:0]      OP_EXP        = 4'h1;
  localparam logic [3:0]      OP_LOG        = 4'h2;
  localparam logic [3:0]      OP_INV        = 4'h3;
  localparam logic [3:0]      OP_AND        = 4'h4;
  localparam logic [3:0]      OP_OR         = 4'h5;
  localparam logic [3:0]      OP_XOR        = 4'h6;
  localparam logic [3:0]      OP_XNOR       = 4'h7;
  // forbidden destination words and pointer bound (packed BCD)
  localparam logic [15:0]     FLT_DEST_LO   = 16'h17FF;
  localparam logic [15:0]     WRD_DEST_LO   = 16'h1800;
  localparam logic [15:0]     DEST_HI       = 16'h19FF;
  localparam logic [15:0]     PTR_LIMIT_DEF = 16'h6655;
  localparam logic [15:0]     THIRD_CONST   = 16'h0000;
endpackage : fmw_pkg

// *** hw/fmw_if.sv ***
// Purpose: link between program sequencer and execution unit
// Assumes: single clock, one request outstanding
// Notes: float operands travel as low and high word
`timescale 1ns/10ps
interface fmw_if;
  logic                           req;
  logic [3:0]                     op;
  logic                           edge_form;
  logic                           cond;
  logic [fmw_pkg::SLOT_W-1:0]     slot;
  logic [fmw_pkg::WORD_W-1:0]     src_lo;
  logic [fmw_pkg::WORD_W-1:0]     src_hi;
  logic [fmw_pkg::WORD_W-1:0]     in1;
  logic [fmw_pkg::WORD_W-1:0]     in2;
  logic [fmw_pkg::WORD_W-1:0]     third;
  logic                           ind;
  logic [fmw_pkg::WORD_W-1:0]     ptr;
  logic                           ack;
  logic                           wr;
  logic [fmw_pkg::WORD_W-1:0]     res_lo;
  logic [fmw_pkg::WORD_W-1:0]     res_hi;
  logic                           fault;
  logic                           zero;
  logic                           ovf;
  logic                           unf;

  modport dev (
    input  req, op, edge_form, cond, slot, src_lo, src_hi, in1, in2, third, ind, ptr,
    output ack, wr, res_lo, res_hi, fault, zero, ovf, unf
  );
  modport seq (
    output req, op, edge_form, cond, slot, src_lo, src_hi, in1, in2, third, ind, ptr,
    input  ack, wr, res_lo, res_hi, fault, zero, ovf, unf
  );
endinterface : fmw_if

// *** hw/fmw_seq.sv ***
// Purpose: sequencer end issuing one instruction per order
// Assumes: orders arrive as one-cycle start pulses
// Notes: orders with a reserved destination are refused locally
`timescale 1ns/10ps
module fmw_seq (
  // clock and reset
  input  wire logic                         clock_i,
  input  wire logic                         rst_n_i,
  // instruction order
  input  wire logic                         start_i,
  input  wire logic [3:0]                   op_i,
  input  wire logic                         edge_form_i,
  input  wire logic                         cond_i,
  input  wire logic [fmw_pkg::SLOT_W-1:0]   slot_i,
  input  wire logic [31:0]                  flt_i,
  input  wire logic [15:0]                  in1_i,
  input  wire logic [15:0]                  in2_i,
  input  wire logic [15:0]                  dest_i,
  input  wire logic                         ind_i,
  input  wire logic [15:0]                  ptr_i,
  // unit link
  fmw_if.seq                                bus,
  // outcome
  output logic                              done_o,
  output logic                              wrote_o,
  output logic                              refused_o,
  output logic [31:0]                       res_o,
  output logic                              fault_o,
  output logic                              zero_o,
  output logic                              ovf_o,
  output logic                              unf_o,
  output logic                              busy_o
);

  wire op_flt   = op_i == fmw_pkg::OP_SQUARE_ROOT_FUNCTION || op_i == fmw_pkg::OP_EXP || op_i == fmw_pkg::OP_LOG;
  wire flt_bad  = dest_i >= fmw_pkg::FLT_DEST_LO && dest_i <= fmw_pkg::DEST_HI;
  wire wrd_bad  = dest_i >= fmw_pkg::WRD_DEST_LO && dest_i <= fmw_pkg::DEST_HI;
  wire dest_bad = op_flt ? flt_bad : wrd_bad;

  ////////////////////////////////////////////////////////////////////////
  // issue and collect
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {bus.req, bus.edge_form, bus.cond, bus.ind} <= '0;
      bus.op    <= fmw_pkg::OP_SQUARE_ROOT_FUNCTION;
      bus.slot  <= '0;
      {bus.src_lo, bus.src_hi, bus.in1, bus.in2, bus.ptr} <= '0;
      bus.third <= fmw_pkg::THIRD_CONST;
      {done_o, wrote_o, refused_o, fault_o, zero_o, ovf_o, unf_o, busy_o} <= '0;
      res_o     <= '0;
    end else begin
      bus.req <= 1'b0;
      done_o  <= 1'b0;
      wrote_o <= 1'b0;
      if (!busy_o && start_i) begin
        refused_o <= dest_bad;
        if (dest_bad) begin
          done_o <= 1'b1;
        end else begin
          bus.req       <= 1'b1;
          busy_o        <= 1'b1;
          bus.op        <= op_i;
          bus.edge_form <= edge_form_i;
          bus.cond      <= cond_i;
          bus.slot      <= slot_i;
          bus.src_lo    <= flt_i[15:0];
          bus.src_hi    <= flt_i[31:16];
          bus.in1       <= in1_i;
          bus.in2       <= in2_i;
          bus.third     <= fmw_pkg::THIRD_CONST;
          bus.ind       <= ind_i;
          bus.ptr       <= ptr_i;
        end
      end else if (busy_o && bus.ack) begin
        busy_o  <= 1'b0;
        done_o  <= 1'b1;
        wrote_o <= bus.wr;
        if (bus.wr) res_o <= {bus.res_hi, bus.res_lo};
        fault_o <= bus.fault;
        zero_o  <= bus.zero;
        ovf_o   <= bus.ovf;
        unf_o   <= bus.unf;
      end
    end
  end

endmodule : fmw_seq

// *** dv/fmw_link_assertions.sv ***
// Purpose: link checks between sequencer and execution unit
// Assumes: one request outstanding, single clock
// Notes: sees only the shared link signals
`timescale 1ns/10ps
module fmw_link_checker #(
  parameter logic [15:0] PTR_LIMIT = 16'h6655
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // link signals
  input  wire logic        req,
  input  wire logic [3:0]  op,
  input  wire logic        edge_form,
  input  wire logic        cond,
  input  wire logic        ind,
  input  wire logic [15:0] ptr,
  input  wire logic [15:0] in1,
  input  wire logic [15:0] in2,
  input  wire logic [15:0] src_hi,
  input  wire logic [15:0] third,
  input  wire logic        ack,
  input  wire logic        wr,
  input  wire logic [15:0] res_lo,
  input  wire logic [15:0] res_hi,
  input  wire logic        fault,
  input  wire logic        zero,
  input  wire logic        ovf,
  input  wire logic        unf
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  // plain direct issue that must execute
  wire logic go = req && cond && !edge_form && !ind;
  wire logic neg_src = src_hi[15] && src_hi[14:7] != 8'h00 && src_hi[14:7] != 8'hFF;
  ////////////////////////////////////////
  a_word_ack_two: assert property (req && op inside {[4'h3:4'h7]} |-> ##2 ack)
    else $error("word op answer late");
  a_cond_off_skip: assert property (req && !cond |-> ##2 ack && !wr)
    else $error("disabled op wrote");
  a_invert_bits: assert property (go && op == fmw_pkg::OP_INV |-> ##2 wr && res_lo == ~$past(in1, 2))
    else $error("invert result wrong");
  a_and_bits: assert property (go && op == fmw_pkg::OP_AND |-> ##2 wr && res_lo == ($past(in1, 2) & $past(in2, 2)))
    else $error("and result wrong");
  a_or_bits: assert property (go && op == fmw_pkg::OP_OR |-> ##2 wr && res_lo == ($past(in1, 2) | $past(in2, 2)))
    else $error("or result wrong");
  a_xor_bits: assert property (go && op == fmw_pkg::OP_XOR |-> ##2 wr && res_lo == ($past(in1, 2) ^ $past(in2, 2)))
    else $error("xor result wrong");
  a_xnor_bits: assert property (go && op == fmw_pkg::OP_XNOR |-> ##2 wr && res_lo == ~($past(in1, 2) ^ $past(in2, 2)))
    else $error("xnor result wrong");
  a_bad_ptr_fault: assert property (req && cond && !edge_form && ind && ptr > PTR_LIMIT |-> ##2 ack && !wr && fault)
    else $error("bad pointer not faulted");
  a_neg_root_fault: assert property (go && op == fmw_pkg::OP_SQUARE_ROOT_FUNCTION && neg_src |-> ##2 ack && !wr && fault)
    else $error("negative root not faulted");
  a_fault_no_write: assert property (ack && fault |-> !wr && !zero)
    else $error("faulted op wrote");
  a_ovf_infinity: assert property (wr && ovf |-> {res_hi[14:0], res_lo} == 31'h7F80_0000)
    else $error("overflow result not infinity");
  a_unf_zero_out: assert property (wr && unf |-> {res_hi, res_lo} == 32'h0000_0000)
    else $error("underflow result not zero");
  a_zero_flag: assert property (wr |-> zero == ({res_hi[14:0], res_lo} == 31'h0))
    else $error("zero flag wrong");
  a_third_zero: assert property (req |-> third == fmw_pkg::THIRD_CONST)
    else $error("third operand not zero");
  c_overflow: cover property (wr && ovf);
  c_underflow: cover property (wr && unf);
  c_fault: cover property (ack && fault);
  c_skip: cover property (ack && !wr && !fault);
endmodule : fmw_link_checker

// *** dv/tb.sv ***
// Purpose: self-checking bench for sequencer and unit
// Assumes: sequencer refuses reserved destinations itself
// Notes: float results compared within 64 ulps
`timescale 1ns/10ps
module tb;
  logic        clock_i     = 1'b0;
  logic        rst_n_i     = 1'b0;
  logic        start_i     = 1'b0;
  logic        edge_form_i = 1'b0;
  logic        cond_i      = 1'b0;
  logic        ind_i       = 1'b0;
  logic [3:0]  op_i        = 4'h0;
  logic [3:0]  slot_i      = 4'h0;
  logic [31:0] flt_i       = 32'h0;
  logic [15:0] in1_i       = 16'h0;
  logic [15:0] in2_i       = 16'h0;
  logic [15:0] dest_i      = 16'h0;
  logic [15:0] ptr_i       = 16'h0;
  logic        done_o, wrote_o, refused_o, fault_o, zero_o, ovf_o, unf_o, busy_o, unit_busy;
  logic [31:0] res_o;
  int          errors  = 0;
  int          checked = 0;
  integer      seed    = 32'h5321BBDF;
  fmw_if bus ();
  always #4 clock_i = ~clock_i;
  fmw_unit u_fmw_unit (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus(bus), .busy_o(unit_busy));
  fmw_seq u_fmw_seq (.clock_i(clock_i), .rst_n_i(rst_n_i), .start_i(start_i), .op_i(op_i),
    .edge_form_i(edge_form_i), .cond_i(cond_i), .slot_i(slot_i), .flt_i(flt_i), .in1_i(in1_i),
    .in2_i(in2_i), .dest_i(dest_i), .ind_i(ind_i), .ptr_i(ptr_i), .bus(bus), .done_o(done_o),
    .wrote_o(wrote_o), .refused_o(refused_o), .res_o(res_o), .fault_o(fault_o), .zero_o(zero_o),
    .ovf_o(ovf_o), .unf_o(unf_o), .busy_o(busy_o));
  fmw_link_checker #(.PTR_LIMIT(fmw_pkg::PTR_LIMIT_DEF)) u_fmw_link_checker (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .req(bus.req), .op(bus.op), .edge_form(bus.edge_form), .cond(bus.cond), .ind(bus.ind), .ptr(bus.ptr),
    .in1(bus.in1), .in2(bus.in2), .src_hi(bus.src_hi), .ack(bus.ack), .wr(bus.wr), .res_lo(bus.res_lo),
    .third(bus.third), .res_hi(bus.res_hi), .fault(bus.fault), .zero(bus.zero), .ovf(bus.ovf), .unf(bus.unf));
  ////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task print_verdict;
    $display("TB: checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task run(input logic [3:0] op, input logic c, input logic e, input logic [3:0] s, input logic [31:0] f,
           input logic [15:0] a, input logic [15:0] b, input logic [15:0] d, input logic i, input logic [15:0] p);
    @(posedge clock_i);
    start_i     <= 1'b1;
    op_i        <= op;
    cond_i      <= c;
    edge_form_i <= e;
    slot_i      <= s;
    flt_i       <= f;
    in1_i       <= a;
    in2_i       <= b;
    dest_i      <= d;
    ind_i       <= i;
    ptr_i       <= p;
    @(posedge clock_i);
    start_i <= 1'b0;
    for (int n = 0; n < 200; n++) begin
      @(negedge clock_i);
      if (done_o === 1'b1) break;
    end
    check({done_o, busy_o, unit_busy}, 3'h4);
  endtask : run
  function logic [15:0] word_exp(input logic [3:0] op, input logic [15:0] a, input logic [15:0] b);
    case (op)
      fmw_pkg::OP_INV: return ~a;
      fmw_pkg::OP_AND: return a & b;
      fmw_pkg::OP_OR:  return a | b;
      fmw_pkg::OP_XOR: return a ^ b;
      default:         return ~(a ^ b);
    endcase
  endfunction : word_exp
  function logic near(input logic [31:0] a, input logic [31:0] b);
    return ((a > b) ? a - b : b - a) <= 32'h40;
  endfunction : near
  ////////////////////////////////////////
  // float cases: op, source, result, {wrote, fault, zero, ovf, unf}
  logic [3:0]  f_op [11] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2};
  logic [31:0] f_src [11] = '{32'h4080_0000, 32'h0, 32'hC080_0000, 32'h7FC0_0000, 32'h4348_0000,
    32'hC348_0000, 32'h3F80_0000, 32'h7F80_0000, 32'hBF80_0000, 32'h0, 32'h402D_F854};
  logic [31:0] f_res [11] = '{32'h4000_0000, 32'h0, 32'h0, 32'h0, 32'h7F80_0000, 32'h0, 32'h402D_F854,
    32'h0, 32'h0, 32'hFF80_0000, 32'h3F80_0000};
  logic [4:0]  f_flg [11] = '{5'h10, 5'h14, 5'h08, 5'h08, 5'h12, 5'h15, 5'h10, 5'h08, 5'h08, 5'h12, 5'h10};
  logic [15:0] a, b, d;
  logic        c;
  initial begin
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'b1;
    for (int k = 0; k < 11; k++) begin
      run(f_op[k], 1'b1, 1'b0, 4'h0, f_src[k], 16'h0, 16'h0, 16'h0200, 1'b0, 16'h0);
      check({wrote_o, fault_o}, f_flg[k][4:3]);
      if (f_flg[k][4]) begin
        check({zero_o, ovf_o, unf_o}, f_flg[k][2:0]);
        check(near(res_o, f_res[k]), 1'b1);
      end
    end
    for (int k = 0; k < 80; k++) begin
      a = (k < 10 && k > 4) ? 16'hFFFF : 16'($random(seed));
      b = (k < 5) ? a : (k < 10) ? 16'h0000 : 16'($random(seed));
      c = (k < 10) ? 1'b1 : 1'($random(seed));
      d = k[0] ? 16'h17FF : 16'h1A00;
      run(4'h3 + 4'(k % 5), c, 1'b0, 4'h0, 32'h0, a, b, d, 1'b0, 16'h0);
      check({refused_o, wrote_o}, {1'b0, c});
      if (c) begin
        check(res_o[15:0], word_exp(4'h3 + 4'(k % 5), a, b));
        check(zero_o, word_exp(4'h3 + 4'(k % 5), a, b) == 16'h0);
      end
    end
    // edge form writes once per rising condition, plain form every time
    for (int k = 0; k < 7; k++) begin
      run(fmw_pkg::OP_INV, 1'(7'h77 >> k), k < 5, 4'h3, 32'h0, 16'h00F0, 16'h0, 16'h0300, 1'b0, 16'h0);
      check(wrote_o, 1'(7'h71 >> k));
    end
    // reserved destinations and their borders
    for (int k = 0; k < 6; k++) begin
      d = (k == 0) ? 16'h17FF : (k == 1) ? 16'h19FF : (k == 2) ? 16'h17FE : (k == 3) ? 16'h1A00 : 16'h1800;
      run(k < 4 ? fmw_pkg::OP_SQUARE_ROOT_FUNCTION : fmw_pkg::OP_AND, 1'b1, 1'b0, 4'h0, 32'h4080_0000, 16'h1, 16'h1,
          (k == 5) ? 16'h19FF : d, 1'b0, 16'h0);
      check({refused_o, wrote_o}, (k == 2 || k == 3) ? 2'b01 : 2'b10);
    end
    // mid-run reset clears outputs and edge history
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(negedge clock_i);
    check({done_o, wrote_o, refused_o, fault_o, zero_o, ovf_o, unf_o, busy_o, unit_busy}, 9'h000);
    check(res_o, 32'h0);
    run(fmw_pkg::OP_INV, 1'b1, 1'b1, 4'h3, 32'h0, 16'h00F0, 16'h0, 16'h0300, 1'b0, 16'h0);
    check({wrote_o, res_o[15:0]}, {1'b1, 16'hFF0F});
    // indirect pointers: past the bound, not packed decimal, on the bound, unknown code
    for (int k = 0; k < 4; k++) begin
      run((k == 3) ? 4'h8 : fmw_pkg::OP_OR, 1'b1, 1'b0, 4'h0, 32'h0, 16'h0003, 16'h0, 16'h0100, 1'b1,
          (k == 0) ? 16'h6656 : (k == 1) ? 16'h12A4 : 16'h6655);
      check({wrote_o, fault_o}, (k == 2) ? 2'b10 : 2'b01);
    end
    print_verdict();
  end
  initial begin
    repeat (40000) @(posedge clock_i);
    errors++;
    $display("ERROR %0t: timeout", $time);
    print_verdict();
  end
endmodule : tb
